// ==== core/pcc_pkg.sv ====
// Constants shared by the power and clock source control block
package pcc_pkg;

  // ********************************************************
  // Register byte addresses
  // ********************************************************
  localparam logic [31:0] ADDR_MAIN_POWER_CONTROL = 32'hFFFF0408;
  localparam logic [31:0] ADDR_MAIN_POWER_KEY = 32'hFFFF040C;
  localparam logic [31:0] ADDR_CLOCK_KEY_PRE = 32'hFFFF0410;
  localparam logic [31:0] ADDR_CLOCK_SOURCE_SELECT = 32'hFFFF0414;
  localparam logic [31:0] ADDR_CLOCK_KEY_POST = 32'hFFFF0418;
  localparam logic [31:0] ADDR_PERIPHERAL_CLOCK_GATE = 32'hFFFF0438;
  localparam logic [31:0] ADDR_PERIPHERAL_GATE_KEY = 32'hFFFF043C;
  localparam logic [31:0] ADDR_POWER_STATUS = 32'hFFFF0440;

  // ********************************************************
  // Key values, compared over the full key width
  // ********************************************************
  localparam int KEY_W = 16;
  localparam logic [15:0] KEY_MAIN_POWER = 16'h00F4;
  localparam logic [15:0] KEY_PERIPH_GATE = 16'h00B1;
  localparam logic [15:0] KEY_CLOCK_PRE = 16'h00AA;
  localparam logic [15:0] KEY_CLOCK_POST = 16'h0055;

  // ********************************************************
  // Field positions, write masks and reset values
  // ********************************************************
  localparam int PWM_BLOCK_ENABLE_BIT = 8;
  localparam int UART_BLOCK_ENABLE_BIT = 5;
  localparam int SERIAL_BLOCKS_ENABLE_BIT = 2;
  localparam logic [15:0] GATE_WRITE_MASK = 16'h0124;
  localparam logic [15:0] GATE_RESET = 16'h0124;
  localparam int EXTERNAL_CLOCK_PIN_SELECT_BIT = 2;
  localparam int OSC_CHOICE_LSB = 0;
  localparam logic [1:0] OSC_CHOICE_CRYSTAL = 2'h2;
  localparam logic [7:0] CLKSRC_WRITE_MASK = 8'h07;
  localparam logic [7:0] CLKSRC_RESET = 8'h00;
  localparam int MODE_LSB = 3;
  localparam int DIVIDER_LSB = 0;
  localparam logic [7:0] MAIN_WRITE_MASK = 8'h7F;
  localparam logic [7:0] MAIN_RESET = 8'h78;

  // ********************************************************
  // Power mode codes
  // ********************************************************
  localparam logic [3:0] MODE_ACTIVE = 4'hF;
  localparam logic [3:0] MODE_PAUSE = 4'hE;
  localparam logic [3:0] MODE_NAP = 4'hC;
  localparam logic [3:0] MODE_SLEEP = 4'h8;
  localparam logic [3:0] MODE_STOP = 4'h0;

  // ********************************************************
  // Timing, times in their printed unit
  // ********************************************************
  localparam int CLK_MHZ = 25;
  localparam int WAKE_LIGHT_CD0_NS = 4800;
  localparam int WAKE_LIGHT_CD7_US = 660;
  localparam int WAKE_DEEP_CD0_US = 66;
  localparam int WAKE_DEEP_CD7_US = 900;
  localparam int POWER_ON_MS = 130;
  localparam int CYC_LIGHT_CD0 = WAKE_LIGHT_CD0_NS * CLK_MHZ / 1000;
  localparam int CYC_LIGHT_CD7 = WAKE_LIGHT_CD7_US * CLK_MHZ;
  localparam int CYC_DEEP_CD0 = WAKE_DEEP_CD0_US * CLK_MHZ;
  localparam int CYC_DEEP_CD7 = WAKE_DEEP_CD7_US * CLK_MHZ;
  localparam int CYC_POWER_ON = POWER_ON_MS * CLK_MHZ * 1000;
  localparam int DIVIDER_MAX = 7;
  localparam int TIMER_W = 22;

  typedef enum logic [1:0] {PCC_POR, PCC_RUN, PCC_LOW, PCC_WAKE} pcc_state_e;

endpackage : pcc_pkg

// ==== core/pcc_key_guard.sv ====
// Holds a protected write until the key arrives on the next bus access
`timescale 1ns/100ps
module pcc_key_guard #(
  parameter int W = 8,
  parameter logic [15:0] KEY = 16'h0000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Bus events
  input wire logic any_strobe,
  input wire logic target_wr,
  input wire logic key_wr,
  input wire logic [15:0] key_data,
  input wire logic [W-1:0] wdata,
  // Result
  output logic commit,
  output logic [W-1:0] commit_data
);

  logic pending_r, pending_nxt;
  logic [W-1:0] data_r, data_nxt;

  // Key must be the very next strobe; any other strobe drops the held value
  always_comb
  begin
    pending_nxt = pending_r;
    data_nxt = data_r;
    if (any_strobe)
      pending_nxt = target_wr;
    if (target_wr)
      data_nxt = wdata;
  end

  // Handshake output is combinational so the register updates on the key edge
  assign commit = pending_r && key_wr && (key_data == KEY);
  assign commit_data = data_r;

  // Registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pending_r <= 1'b0;
      data_r <= '0;
    end
    else
    begin
      pending_r <= pending_nxt;
      data_r <= data_nxt;
    end
  end

endmodule : pcc_key_guard

// ==== core/pcc_wake_timer.sv ====
// Down counter that times power-on and wake-up intervals
`timescale 1ns/100ps
module pcc_wake_timer #(
  parameter int W = 22
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  input wire logic start,
  input wire logic [W-1:0] load,
  // Status
  output logic busy,
  output logic done
);

  logic [W-1:0] cnt_r, cnt_nxt;
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;

  // A start while busy restarts the interval
  always_comb
  begin
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (start)
    begin
      cnt_nxt = load;
      busy_nxt = 1'b1;
    end
    else if (busy_r)
    begin
      if (cnt_r <= W'(1))
      begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
      else
        cnt_nxt = cnt_r - W'(1);
    end
  end

  assign busy = busy_r;
  assign done = done_r;

  // Registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

endmodule : pcc_wake_timer

// ==== core/pcc_top.sv ====
// Power mode and clock source control with key-protected registers
//
// Contract
// - Gate bit 8 enables the PWM clock when set, stops it when clear, and resets set.
// - Gate bit 5 enables the UART clock when set, stops it when clear, and resets set.
// - Gate bit 2 enables the I2C and SPI clocks when set, stops them when clear, resets set.
// - A gate write takes effect only when 0xB1 goes to the gate key on the next access.
// - The 4-bit mode field picks active 1111, pause 1110, nap 1100, sleep 1000, stop 0000.
// - Wake from pause or nap takes 4.8 us at divider 0 up to 660 us at divider 7.
// - Wake from sleep or stop takes 66 us to 900 us; power-on to active takes 130 ms.
// - A clock source write must be preceded directly by 0xAA to the first clock key.
// - A clock source write takes effect only when 0x55 goes to the second clock key next.
// - Clock source bit 2 selects the external clock pin for the PLL, clear disables it.
// - Oscillator code 10 picks the crystal, other codes the internal oscillator; reset 0x00.
// - A main power control write takes effect only when 0xF4 follows it at the power key.
`timescale 1ns/100ps
module pcc_top #(
  parameter int CYC_LIGHT_CD7_P = pcc_pkg::CYC_LIGHT_CD7,
  parameter int CYC_DEEP_CD7_P = pcc_pkg::CYC_DEEP_CD7,
  parameter int CYC_POWER_ON_P = pcc_pkg::CYC_POWER_ON
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Wake pins
  input wire logic [3:0] wake_interrupt_inputs,
  // Clock domain enables
  output logic core_clock_run,
  output logic periph_clock_run,
  output logic pll_run,
  output logic crystal_run,
  output logic timers_two_three_run,
  output logic wake_inputs_live,
  // Peripheral clock enables
  output logic pwm_clock_en,
  output logic uart_clock_en,
  output logic serial_clock_en,
  // PLL source selection
  output logic pll_src_ext_pin,
  output logic pll_src_crystal,
  output logic pll_src_internal
);
  import pcc_pkg::*;

  // ********************************************************
  // Bus decode
  // ********************************************************
  logic any_strobe;
  logic wr_main, wr_main_key, wr_pre, wr_src, wr_post, wr_gate, wr_gate_key;

  assign any_strobe = wr || rd;
  assign wr_main = wr && (addr == ADDR_MAIN_POWER_CONTROL);
  assign wr_main_key = wr && (addr == ADDR_MAIN_POWER_KEY);
  assign wr_pre = wr && (addr == ADDR_CLOCK_KEY_PRE);
  assign wr_src = wr && (addr == ADDR_CLOCK_SOURCE_SELECT);
  assign wr_post = wr && (addr == ADDR_CLOCK_KEY_POST);
  assign wr_gate = wr && (addr == ADDR_PERIPHERAL_CLOCK_GATE);
  assign wr_gate_key = wr && (addr == ADDR_PERIPHERAL_GATE_KEY);

  // ********************************************************
  // Key protection
  // ********************************************************
  logic armed_r, armed_nxt;
  logic gate_commit, src_commit, main_commit;
  logic [15:0] gate_commit_data;
  logic [7:0] src_commit_data, main_commit_data;

  // Pre-key arms only the very next access
  always_comb
  begin
    armed_nxt = armed_r;
    if (any_strobe)
      armed_nxt = wr_pre && (wdata[KEY_W-1:0] == KEY_CLOCK_PRE);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      armed_r <= 1'b0;
    else
      armed_r <= armed_nxt;
  end

  // Gate write waits for its post key
  pcc_key_guard #(.W(16), .KEY(KEY_PERIPH_GATE)) u_gate_guard (
    .clk(clk),
    .arst_n(arst_n),
    .any_strobe(any_strobe),
    .target_wr(wr_gate),
    .key_wr(wr_gate_key),
    .key_data(wdata[KEY_W-1:0]),
    .wdata(wdata[15:0] & GATE_WRITE_MASK),
    .commit(gate_commit),
    .commit_data(gate_commit_data)
  );

  // Source write counts only when armed, then waits for its post key
  pcc_key_guard #(.W(8), .KEY(KEY_CLOCK_POST)) u_src_guard (
    .clk(clk),
    .arst_n(arst_n),
    .any_strobe(any_strobe),
    .target_wr(wr_src && armed_r),
    .key_wr(wr_post),
    .key_data(wdata[KEY_W-1:0]),
    .wdata(wdata[7:0] & CLKSRC_WRITE_MASK),
    .commit(src_commit),
    .commit_data(src_commit_data)
  );

  // Main power control waits for its power key
  pcc_key_guard #(.W(8), .KEY(KEY_MAIN_POWER)) u_main_guard (
    .clk(clk),
    .arst_n(arst_n),
    .any_strobe(any_strobe),
    .target_wr(wr_main),
    .key_wr(wr_main_key),
    .key_data(wdata[KEY_W-1:0]),
    .wdata(wdata[7:0] & MAIN_WRITE_MASK),
    .commit(main_commit),
    .commit_data(main_commit_data)
  );

  // ********************************************************
  // Wake pin synchroniser
  // ********************************************************
  logic [3:0] s1_r, s2_r, s3_r, wake_lvl_r;
  logic [3:0] wake_lvl_nxt;

  // Each pin updates only when the second and third stage agree
  always_comb
  begin
    wake_lvl_nxt = wake_lvl_r;
    for (int i = 0; i < 4; i++)
      if (s2_r[i] == s3_r[i])
        wake_lvl_nxt[i] = s3_r[i];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
      s3_r <= 4'h0;
      wake_lvl_r <= 4'h0;
    end
    else
    begin
      s1_r <= wake_interrupt_inputs;
      s2_r <= s1_r;
      s3_r <= s2_r;
      wake_lvl_r <= wake_lvl_nxt;
    end
  end

  // ********************************************************
  // Wake timing
  // ********************************************************
  // Straight line between the divider 0 and divider 7 figures, rounded down
  function automatic logic [TIMER_W-1:0] wake_cycles(input int c0, input int c7,
                                                     input logic [2:0] cd);
    int c;
    c = c0 + ((c7 - c0) * int'(cd)) / DIVIDER_MAX;
    if (c < 1)
      c = 1;
    return TIMER_W'(c);
  endfunction : wake_cycles

  // ********************************************************
  // Registers and power state
  // ********************************************************
  logic [15:0] gate_r, gate_nxt;
  logic [7:0] src_r, src_nxt;
  logic [7:0] main_r, main_nxt;
  pcc_state_e state_r, state_nxt;
  logic tmr_start;
  logic [TIMER_W-1:0] tmr_load;
  logic tmr_busy, tmr_done;
  logic [3:0] mode;
  logic [2:0] divider;
  logic deep;

  assign mode = main_r[MODE_LSB +: 4];
  assign divider = main_r[DIVIDER_LSB +: 3];
  assign deep = (mode == MODE_SLEEP) || (mode == MODE_STOP);

  // Power-on hold, run, low power, wake; wake level beats a late write
  always_comb
  begin
    gate_nxt = gate_r;
    src_nxt = src_r;
    main_nxt = main_r;
    state_nxt = state_r;
    tmr_start = 1'b0;
    tmr_load = TIMER_W'(CYC_POWER_ON_P);
    if (gate_commit)
      gate_nxt = gate_commit_data;
    if (src_commit)
      src_nxt = src_commit_data;
    case (state_r)
      PCC_POR:
      begin
        if (tmr_done)
          state_nxt = PCC_RUN;
      end
      PCC_RUN:
      begin
        if (main_commit)
        begin
          main_nxt = main_commit_data;
          if (main_commit_data[MODE_LSB +: 4] != MODE_ACTIVE)
            state_nxt = PCC_LOW;
        end
      end
      PCC_LOW:
      begin
        // Wake pins are never gated, in any mode
        if (wake_lvl_r != 4'h0)
        begin
          state_nxt = PCC_WAKE;
          tmr_start = 1'b1;
          if (deep)
            tmr_load = wake_cycles(CYC_DEEP_CD0, CYC_DEEP_CD7_P, divider);
          else
            tmr_load = wake_cycles(CYC_LIGHT_CD0, CYC_LIGHT_CD7_P, divider);
        end
      end
      PCC_WAKE:
      begin
        if (tmr_done)
        begin
          state_nxt = PCC_RUN;
          main_nxt[MODE_LSB +: 4] = MODE_ACTIVE;
        end
      end
      default:
        state_nxt = PCC_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gate_r <= GATE_RESET;
      src_r <= CLKSRC_RESET;
      main_r <= MAIN_RESET;
      state_r <= PCC_POR;
    end
    else
    begin
      gate_r <= gate_nxt;
      src_r <= src_nxt;
      main_r <= main_nxt;
      state_r <= state_nxt;
    end
  end

  // Power-on interval starts from the first edge after reset
  logic por_kick_r;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      por_kick_r <= 1'b1;
    else
      por_kick_r <= 1'b0;
  end

  pcc_wake_timer #(.W(TIMER_W)) u_timer (
    .clk(clk),
    .arst_n(arst_n),
    .start(tmr_start || por_kick_r),
    .load(tmr_load),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // ********************************************************
  // Clock enables
  // ********************************************************
  logic core_nxt, periph_nxt, pll_nxt, xtal_nxt;

  // Undefined mode codes are treated as active so the part never locks up
  always_comb
  begin
    core_nxt = 1'b1;
    periph_nxt = 1'b1;
    pll_nxt = 1'b1;
    xtal_nxt = 1'b1;
    if (state_nxt == PCC_POR)
    begin
      core_nxt = 1'b0;
      periph_nxt = 1'b0;
    end
    else if (state_nxt == PCC_WAKE)
      core_nxt = 1'b0; // Oscillators restart before the core resumes
    else if (state_nxt == PCC_LOW)
    begin
      case (main_nxt[MODE_LSB +: 4])
        MODE_PAUSE:
          core_nxt = 1'b0;
        MODE_NAP:
        begin
          core_nxt = 1'b0;
          periph_nxt = 1'b0;
        end
        MODE_SLEEP:
        begin
          core_nxt = 1'b0;
          periph_nxt = 1'b0;
          pll_nxt = 1'b0;
        end
        MODE_STOP:
        begin
          core_nxt = 1'b0;
          periph_nxt = 1'b0;
          pll_nxt = 1'b0;
          xtal_nxt = 1'b0;
        end
        default:
          core_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      core_clock_run <= 1'b0;
      periph_clock_run <= 1'b0;
      pll_run <= 1'b1;
      crystal_run <= 1'b1;
      pwm_clock_en <= 1'b0;
      uart_clock_en <= 1'b0;
      serial_clock_en <= 1'b0;
    end
    else
    begin
      core_clock_run <= core_nxt;
      periph_clock_run <= periph_nxt;
      pll_run <= pll_nxt;
      crystal_run <= xtal_nxt;
      pwm_clock_en <= periph_nxt && gate_nxt[PWM_BLOCK_ENABLE_BIT];
      uart_clock_en <= periph_nxt && gate_nxt[UART_BLOCK_ENABLE_BIT];
      serial_clock_en <= periph_nxt && gate_nxt[SERIAL_BLOCKS_ENABLE_BIT];
    end
  end

  // Timers two and three share the crystal domain
  assign timers_two_three_run = crystal_run;
  assign wake_inputs_live = arst_n;

  // Source select straight from the stored register
  assign pll_src_ext_pin = src_r[EXTERNAL_CLOCK_PIN_SELECT_BIT];
  assign pll_src_crystal = !src_r[EXTERNAL_CLOCK_PIN_SELECT_BIT] &&
                           (src_r[OSC_CHOICE_LSB +: 2] == OSC_CHOICE_CRYSTAL);
  assign pll_src_internal = !pll_src_ext_pin && !pll_src_crystal;

  // ********************************************************
  // Read data
  // ********************************************************
  logic [31:0] rdata_r, rdata_nxt;

  // Keys are write-only and unmapped addresses read zero
  always_comb
  begin
    rdata_nxt = 32'h00000000;
    if (rd)
    begin
      case (addr)
        ADDR_MAIN_POWER_CONTROL:
          rdata_nxt = {24'h000000, main_r};
        ADDR_CLOCK_SOURCE_SELECT:
          rdata_nxt = {24'h000000, src_r};
        ADDR_PERIPHERAL_CLOCK_GATE:
          rdata_nxt = {16'h0000, gate_r};
        ADDR_POWER_STATUS:
          rdata_nxt = {26'h0000000, tmr_busy, wake_lvl_r != 4'h0, state_r == PCC_POR,
                       state_r == PCC_WAKE, armed_r, state_r != PCC_POR};
        default:
          rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_r <= 32'h00000000;
    else
      rdata_r <= rdata_nxt;
  end

  assign rdata = rdata_r;

endmodule : pcc_top

// ==== tb/pcc_top_properties.sv ====
// Port-level assertions for the power and clock source control block
`timescale 1ns/100ps
module pcc_top_properties
  import pcc_pkg::*;
#(
  parameter int CYC_POWER_ON_P = CYC_POWER_ON
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  // Domain enables
  input wire logic core_clock_run,
  input wire logic periph_clock_run,
  input wire logic pll_run,
  input wire logic crystal_run,
  input wire logic timers_two_three_run,
  input wire logic wake_inputs_live,
  // Peripheral enables and PLL source
  input wire logic pwm_clock_en,
  input wire logic uart_clock_en,
  input wire logic serial_clock_en,
  input wire logic pll_src_ext_pin,
  input wire logic pll_src_crystal,
  input wire logic pll_src_internal
);
  // ************************************************
  // Helper logic
  // ************************************************
  int por_cnt_r;
  int por_cnt_nxt;
  logic gate_key_wr;
  logic post_key_wr;
  logic [2:0] src;
  logic [2:0] gates;
  // Saturating count since reset release, so long runs never wrap
  always_comb
  begin
    por_cnt_nxt = (por_cnt_r < CYC_POWER_ON_P) ? por_cnt_r + 1 : por_cnt_r;
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      por_cnt_r <= 0;
    else
      por_cnt_r <= por_cnt_nxt;
  end
  // Key strobes decoded from the bus
  assign gate_key_wr = wr && addr == ADDR_PERIPHERAL_GATE_KEY && wdata[15:0] == KEY_PERIPH_GATE;
  assign post_key_wr = wr && addr == ADDR_CLOCK_KEY_POST && wdata[15:0] == KEY_CLOCK_POST;
  assign src = {pll_src_ext_pin, pll_src_crystal, pll_src_internal};
  assign gates = {pwm_clock_en, uart_clock_en, serial_clock_en};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // ************************************************
  // Assertions
  // ************************************************
  chk_power_on_hold: assert property ((por_cnt_r < CYC_POWER_ON_P - 1) |-> !core_clock_run)
    else $error("core clock ran during the power-on hold");
  chk_wake_live: assert property (wake_inputs_live)
    else $error("wake inputs not live");
  chk_timers_crystal: assert property (timers_two_three_run == crystal_run)
    else $error("timer domain differs from crystal");
  chk_core_nesting: assert property (core_clock_run |-> periph_clock_run && pll_run)
    else $error("core runs with a deeper domain stopped");
  chk_crystal_nesting: assert property (!crystal_run |-> !pll_run && !periph_clock_run)
    else $error("domain runs with crystal stopped");
  chk_src_onehot: assert property ($onehot(src))
    else $error("PLL source select not one-hot");
  chk_src_key: assert property (!$stable(src) |-> $past(post_key_wr))
    else $error("PLL source changed without post key");
  chk_gate_key: assert property (($changed(gates) && periph_clock_run
    && $past(periph_clock_run) && $past(periph_clock_run, 2)) |-> $past(gate_key_wr))
    else $error("peripheral enable changed without gate key");
  chk_gate_domain: assert property ((|gates) |->
    periph_clock_run || $past(periph_clock_run))
    else $error("peripheral enable high with domain stopped");

  // Main scenarios reached
  cov_core_stop: cover property ($fell(core_clock_run));
  cov_core_wake: cover property ($rose(core_clock_run));
  cov_crystal_src: cover property ($rose(pll_src_crystal));
  cov_pwm_off: cover property ($fell(pwm_clock_en));
endmodule : pcc_top_properties

bind pcc_top pcc_top_properties #(.CYC_POWER_ON_P(CYC_POWER_ON_P)) u_props (
  .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
  .core_clock_run(core_clock_run), .periph_clock_run(periph_clock_run), .pll_run(pll_run),
  .crystal_run(crystal_run), .timers_two_three_run(timers_two_three_run),
  .wake_inputs_live(wake_inputs_live), .pwm_clock_en(pwm_clock_en),
  .uart_clock_en(uart_clock_en), .serial_clock_en(serial_clock_en),
  .pll_src_ext_pin(pll_src_ext_pin), .pll_src_crystal(pll_src_crystal),
  .pll_src_internal(pll_src_internal)
);

// ==== tb/pcc_top_bench.sv ====
// Directed register-level bench for the power and clock source control block
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got 0x%0h expected 0x%0h", $time, (g), (e)); end end
module pcc_top_bench;
  import pcc_pkg::*;
  // ************************************************
  // Shortened counts keep the run brief
  // ************************************************
  localparam int P_ON = 20;
  localparam int P_LIGHT7 = 40;
  localparam int P_DEEP7 = 60;
  localparam logic [3:0] MODE_TAB [4] = '{MODE_PAUSE, MODE_NAP, MODE_SLEEP, MODE_STOP};
  localparam logic [2:0] CD_TAB [4] = '{3'h0, 3'h7, 3'h0, 3'h7};
  localparam int LO_TAB [4] = '{CYC_LIGHT_CD0, P_LIGHT7, CYC_DEEP_CD0, P_DEEP7};
  localparam logic [3:0] DOM_TAB [4] = '{4'h7, 4'h3, 4'h1, 4'h0};
  logic clk;
  logic arst_n;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [3:0] wake_in;
  logic core_r, periph_r, pll_r, xtal_r, timers_r, live_r, pwm_en, uart_en, ser_en;
  logic src_ext, src_xtal, src_int;
  logic [3:0] doms;
  logic [2:0] gates;
  logic [2:0] srcs;
  logic [15:0] gval;
  int gbit;
  int n;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  assign doms = {core_r, periph_r, pll_r, xtal_r};
  assign gates = {pwm_en, uart_en, ser_en};
  assign srcs = {src_ext, src_xtal, src_int};

  pcc_top #(.CYC_LIGHT_CD7_P(P_LIGHT7), .CYC_DEEP_CD7_P(P_DEEP7), .CYC_POWER_ON_P(P_ON)) u_dut (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .wake_interrupt_inputs(wake_in), .core_clock_run(core_r), .periph_clock_run(periph_r),
    .pll_run(pll_r), .crystal_run(xtal_r), .timers_two_three_run(timers_r),
    .wake_inputs_live(live_r), .pwm_clock_en(pwm_en), .uart_clock_en(uart_en),
    .serial_clock_en(ser_en), .pll_src_ext_pin(src_ext), .pll_src_crystal(src_xtal),
    .pll_src_internal(src_int)
  );

  // ************************************************
  // Bus tasks
  // ************************************************
  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
  begin
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  end
  endtask : bus_wr
  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic bus_rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
  begin
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata & m, e)
  end
  endtask : bus_rd
  task automatic settle();
  begin
    @(posedge clk);
    #1;
  end
  endtask : settle
  task automatic src_wr(input logic [15:0] k1, input logic [7:0] v, input logic [15:0] k2);
  begin
    bus_wr(ADDR_CLOCK_KEY_PRE, {16'h0, k1});
    bus_wr(ADDR_CLOCK_SOURCE_SELECT, {24'h0, v});
    bus_wr(ADDR_CLOCK_KEY_POST, {16'h0, k2});
    settle();
  end
  endtask : src_wr
  task automatic close_out();
  begin
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask : close_out

  // ************************************************
  // Clock and hang guard
  // ************************************************
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Longest path is the deep wake, well under this ceiling
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  // ************************************************
  // Main sequence
  // ************************************************
  initial
  begin
    arst_n = 1'b0;
    addr = 32'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    wake_in = 4'h0;
    repeat (16) @(posedge clk);
    `CHK(srcs, 3'b001)
    arst_n <= 1'b1;
    n = 0;
    while (core_r !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(n >= P_ON - 1 && n <= P_ON + 3, 1'b1)
    `CHK({timers_r, live_r}, 2'b11)
    // Status: out of power-on, nothing armed, not waking
    bus_rd(ADDR_POWER_STATUS, 32'h3F, 32'h01);
    bus_rd(ADDR_PERIPHERAL_CLOCK_GATE, 32'hFFFF, 32'h0124);
    bus_rd(ADDR_CLOCK_SOURCE_SELECT, 32'hFF, 32'h00);
    `CHK(gates, 3'b111)
    // Each enable bit cleared alone, reserved bits written high to see them masked
    for (int i = 0; i < 3; i++)
    begin
      gbit = (i == 0) ? 8 : (i == 1) ? 5 : 2;
      gval = GATE_RESET & ~(16'h1 << gbit);
      bus_wr(ADDR_PERIPHERAL_CLOCK_GATE, 32'h0000FFFF & ~(32'h1 << gbit));
      bus_wr(ADDR_PERIPHERAL_GATE_KEY, 32'hFFFF00B1);
      settle();
      `CHK(gates, ~(3'b100 >> i))
      bus_rd(ADDR_PERIPHERAL_CLOCK_GATE, 32'hFFFF, {16'h0, gval});
      bus_wr(ADDR_PERIPHERAL_CLOCK_GATE, 32'h0);
      bus_wr(ADDR_PERIPHERAL_GATE_KEY, 32'h00B0);
      bus_rd(ADDR_PERIPHERAL_CLOCK_GATE, 32'hFFFF, {16'h0, gval});
      bus_wr(ADDR_PERIPHERAL_CLOCK_GATE, 32'h0124);
      bus_wr(ADDR_PERIPHERAL_GATE_KEY, 32'h00B1);
    end
    // Every source code, reserved bits set
    for (int c = 0; c < 8; c++)
    begin
      src_wr(16'h00AA, 8'hF8 | 8'(c), 16'h0055);
      `CHK(srcs, c[2] ? 3'b100 : (c[1:0] == 2'h2) ? 3'b010 : 3'b001)
      bus_rd(ADDR_CLOCK_SOURCE_SELECT, 32'hFF, 32'(c));
    end
    src_wr(16'h00AB, 8'h02, 16'h0055);
    bus_rd(ADDR_CLOCK_SOURCE_SELECT, 32'hFF, 32'h07);
    src_wr(16'h00AA, 8'h02, 16'h0056);
    bus_rd(ADDR_CLOCK_SOURCE_SELECT, 32'hFF, 32'h07);
    // A read between mode write and key voids the key
    bus_wr(ADDR_MAIN_POWER_CONTROL, {25'h0, MODE_PAUSE, 3'h0});
    bus_rd(ADDR_MAIN_POWER_CONTROL, 32'h7F, 32'h78);
    bus_wr(ADDR_MAIN_POWER_KEY, 32'h00F4);
    settle();
    `CHK(doms, 4'hF)
    for (int m = 0; m < 4; m++)
    begin
      bus_wr(ADDR_MAIN_POWER_CONTROL, {25'h0, MODE_TAB[m], CD_TAB[m]});
      bus_wr(ADDR_MAIN_POWER_KEY, 32'h00F4);
      settle();
      `CHK(doms, DOM_TAB[m])
      // Timers follow the crystal column; wake inputs stay live in every mode
      `CHK({timers_r, live_r}, {DOM_TAB[m][0], 1'b1})
      wake_in <= 4'h1 << m;
      n = 0;
      while (core_r !== 1'b1 && n < 3000)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      `CHK(n >= LO_TAB[m] && n <= LO_TAB[m] + 16, 1'b1)
      wake_in <= 4'h0;
      bus_rd(ADDR_MAIN_POWER_CONTROL, 32'h7F, {25'h0, MODE_ACTIVE, CD_TAB[m]});
    end
    close_out();
  end
endmodule : pcc_top_bench
